// >>> shared/clc_map.vh
// Purpose: register map, field positions, reset values and mode codes of the configurable logic cell
// Assumes: 16-bit registers reached by word index over a plain strobe port
// Notes:   included by the cell top, the property module and the bench; the gate module and the source model do not include it
//
// How it works
// [RL1] mode 000: AND-OR of the four gates
// [RL2] mode 001: OR-XOR of the four gates
// [RL3] mode 010: AND of all four gates
// [RL4] mode 011: set-reset latch from gates
// [RL5] mode 100: D flip-flop with set and reset
// [RL6] mode 101: two-input D flip-flop with reset
// [RL7] mode 110: JK flip-flop with reset
// [RL8] mode 111: transparent latch with set, reset
// [RL9] polarity bit 1 inverts its gate output
// [RL10] polarity bit 0 passes gate, reset value
// [RL11] control high bits 15-4 read zero
// [RL12] gate two true enables, odd high bits
// [RL13] gate two negated enables, even high bits
// [RL14] gate one true enables, bits 7, 5, 3, 1
// [RL15] gate one negated enables, bits 6, 4, 2, 0
// [RL16] gate ORs enabled forms, none gives zero
`ifndef CLC_MAP_VH
`define CLC_MAP_VH

// ----------------------------------------------------------------
// bus geometry
// ----------------------------------------------------------------
`define CLC_ADDR_W 4
`define CLC_DATA_W 16

// ----------------------------------------------------------------
// register indices
// ----------------------------------------------------------------
`define CLC_IDX_CTRL_LO 4'h0
`define CLC_IDX_CTRL_HI 4'h1
`define CLC_IDX_SEL_LO  4'h2
`define CLC_IDX_SEL_HI  4'h3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CLC_RST_CTRL_LO 16'h0000
`define CLC_RST_CTRL_HI 4'h0
`define CLC_RST_SEL_LO  16'h0000
`define CLC_RST_SEL_HI  16'h0000

// ----------------------------------------------------------------
// control low fields
// ----------------------------------------------------------------
`define CLC_CL_ENABLE   15
`define CLC_CL_GATES_HI 11
`define CLC_CL_GATES_LO 8
`define CLC_CL_OUT      5
`define CLC_CL_MODE_HI  2
`define CLC_CL_MODE_LO  0
`define CLC_CL_WR_MASK  16'h8007

// ----------------------------------------------------------------
// cell modes
// ----------------------------------------------------------------
`define CLC_MODE_AND_OR  3'h0
`define CLC_MODE_OR_XOR  3'h1
`define CLC_MODE_AND4    3'h2
`define CLC_MODE_SR      3'h3
`define CLC_MODE_DFF_SR  3'h4
`define CLC_MODE_DFF2_R  3'h5
`define CLC_MODE_JK_R    3'h6
`define CLC_MODE_LATCH   3'h7

`endif

// >>> rtl/clc_gate.v
// Purpose: one input gate of the logic cell
// Assumes: data sources already synchronous to the system clock
// Notes:   purely combinational; the cell registers the result
`timescale 1ns/1ps

module clc_gate
(
  input  wire [3:0] src,
  input  wire [3:0] true_en,
  input  wire [3:0] neg_en,
  input  wire       invert,
  output wire       gate_out
);

  // ----------------------------------------------------------------
  // or of enabled forms
  // ----------------------------------------------------------------
  wire [3:0] true_terms;
  wire [3:0] neg_terms;
  wire       raw_or;

  assign true_terms = src & true_en;
  assign neg_terms  = (~src) & neg_en;
  // nothing enabled leaves every term low, so the gate reads zero
  assign raw_or     = |{true_terms, neg_terms};  // [RL16]

  // ----------------------------------------------------------------
  // polarity
  // ----------------------------------------------------------------
  assign gate_out = invert ? ~raw_or : raw_or;  // [RL9] [RL10]

endmodule // clc_gate

// >>> rtl/clc_cell.v
// Purpose: configurable logic cell with four input gates and eight cell functions
// Assumes: single clock; data sources synchronous; register port never stalls
// Notes:   every cell function, latches included, is evaluated on the system clock
`timescale 1ns/1ps
`include "clc_map.vh"

module clc_cell
(
  input  wire                   clk,
  input  wire                   arst_n,
  input  wire [`CLC_ADDR_W-1:0] reg_addr,
  input  wire [`CLC_DATA_W-1:0] reg_wdata,
  input  wire                   reg_wr,
  input  wire                   reg_rd,
  output reg  [`CLC_DATA_W-1:0] reg_rdata,
  input  wire [3:0]             data_src,
  output reg                    cell_out
);

  // ----------------------------------------------------------------
  // select field helpers
  // ----------------------------------------------------------------
  // each gate owns one byte: true enable above negated, source 4 on top
  function [3:0] true_en_of;
    input [7:0] sel_byte;
    begin
      true_en_of = {sel_byte[7], sel_byte[5], sel_byte[3], sel_byte[1]};
    end
  endfunction

  function [3:0] neg_en_of;
    input [7:0] sel_byte;
    begin
      neg_en_of = {sel_byte[6], sel_byte[4], sel_byte[2], sel_byte[0]};
    end
  endfunction

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg  [`CLC_DATA_W-1:0] cell_control_low;
  reg  [3:0]             cell_control_high;
  reg  [`CLC_DATA_W-1:0] gate_input_select_low;
  reg  [`CLC_DATA_W-1:0] gate_input_select_high;
  reg  [`CLC_DATA_W-1:0] next_rdata;

  wire [2:0] mode;
  wire       cell_enable;
  wire       gate_one_invert;
  wire       gate_two_invert;
  wire       gate_three_invert;
  wire       gate_four_invert;

  assign mode              = cell_control_low[`CLC_CL_MODE_HI:`CLC_CL_MODE_LO];
  assign cell_enable       = cell_control_low[`CLC_CL_ENABLE];
  assign gate_one_invert   = cell_control_high[0];
  assign gate_two_invert   = cell_control_high[1];
  assign gate_three_invert = cell_control_high[2];
  assign gate_four_invert  = cell_control_high[3];

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  // combinational modes keep no state, so a later switch to a
  // sequential mode always starts from a cleared cell
  function mode_is_comb;
    input [2:0] mode_code;
    begin
      mode_is_comb = (mode_code == `CLC_MODE_AND_OR) |
                     (mode_code == `CLC_MODE_OR_XOR) |
                     (mode_code == `CLC_MODE_AND4);
    end
  endfunction

  wire comb_mode;

  assign comb_mode = mode_is_comb(mode);

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cell_control_low       <= `CLC_RST_CTRL_LO;
      cell_control_high      <= `CLC_RST_CTRL_HI;  // [RL10]
      gate_input_select_low  <= `CLC_RST_SEL_LO;
      gate_input_select_high <= `CLC_RST_SEL_HI;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `CLC_IDX_CTRL_LO:
          // status bits are not writable; only enable and mode store
          cell_control_low <= reg_wdata & `CLC_CL_WR_MASK;
        `CLC_IDX_CTRL_HI:
          cell_control_high <= reg_wdata[3:0];  // [RL9]
        `CLC_IDX_SEL_LO:
          gate_input_select_low <= reg_wdata;  // [RL12] [RL13] [RL14] [RL15]
        `CLC_IDX_SEL_HI:
          gate_input_select_high <= reg_wdata;
        default:
          ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // gates
  // ----------------------------------------------------------------
  wire [3:0] gate;

  clc_gate u_gate_one
  (
    .src      (data_src),
    .true_en  (true_en_of(gate_input_select_low[7:0])),  // [RL14]
    .neg_en   (neg_en_of(gate_input_select_low[7:0])),   // [RL15]
    .invert   (gate_one_invert),
    .gate_out (gate[0])
  );

  clc_gate u_gate_two
  (
    .src      (data_src),
    .true_en  (true_en_of(gate_input_select_low[15:8])),  // [RL12]
    .neg_en   (neg_en_of(gate_input_select_low[15:8])),   // [RL13]
    .invert   (gate_two_invert),
    .gate_out (gate[1])
  );

  clc_gate u_gate_three
  (
    .src      (data_src),
    .true_en  (true_en_of(gate_input_select_high[7:0])),
    .neg_en   (neg_en_of(gate_input_select_high[7:0])),
    .invert   (gate_three_invert),
    .gate_out (gate[2])
  );

  clc_gate u_gate_four
  (
    .src      (data_src),
    .true_en  (true_en_of(gate_input_select_high[15:8])),
    .neg_en   (neg_en_of(gate_input_select_high[15:8])),
    .invert   (gate_four_invert),
    .gate_out (gate[3])
  );

  // ----------------------------------------------------------------
  // gate roles in the sequential modes
  // ----------------------------------------------------------------
  // gate 1 is the clock, latch enable or set, gate 2 data or J or set,
  // gate 3 reset, gate 4 set, reset, second data or K
  wire g1;
  wire g2;
  wire g3;
  wire g4;

  assign g1 = gate[0];
  assign g2 = gate[1];
  assign g3 = gate[2];
  assign g4 = gate[3];

  reg  g1_prev;
  wire g1_rise;

  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      g1_prev <= 1'b0;
    end
    else
    begin
      g1_prev <= g1;
    end
  end

  // the gated clock is sampled, so it must stay at each level a full cycle
  assign g1_rise = g1 & ~g1_prev;

  // ----------------------------------------------------------------
  // combinational functions
  // ----------------------------------------------------------------
  wire and_or_val;
  wire or_xor_val;
  wire and4_val;

  assign and_or_val = (g1 & g2) | (g3 & g4);  // [RL1]
  assign or_xor_val = (g1 | g2) ^ (g3 | g4);  // [RL2]
  assign and4_val   = g1 & g2 & g3 & g4;      // [RL3]

  // ----------------------------------------------------------------
  // sequential functions
  // ----------------------------------------------------------------
  reg  cell_state;
  reg  next_state;
  wire sr_set;
  wire sr_reset;
  wire dff2_data;

  assign sr_set    = g1 | g2;
  assign sr_reset  = g3 | g4;
  assign dff2_data = g2 & g4;

  always @*
  begin
    next_state = cell_state;
    case (mode)
      `CLC_MODE_SR:
      begin
        // set dominates when both sides assert together
        if (sr_set)
          next_state = 1'b1;  // [RL4]
        else if (sr_reset)
          next_state = 1'b0;  // [RL4]
      end
      `CLC_MODE_DFF_SR:
      begin
        if (g3)
          next_state = 1'b0;  // [RL5]
        else if (g4)
          next_state = 1'b1;  // [RL5]
        else if (g1_rise)
          next_state = g2;  // [RL5]
      end
      `CLC_MODE_DFF2_R:
      begin
        if (g3)
          next_state = 1'b0;  // [RL6]
        else if (g1_rise)
          next_state = dff2_data;  // [RL6]
      end
      `CLC_MODE_JK_R:
      begin
        if (g3)
          next_state = 1'b0;  // [RL7]
        else if (g1_rise)
        begin
          case ({g2, g4})
            2'h1:    next_state = 1'b0;
            2'h2:    next_state = 1'b1;
            2'h3:    next_state = ~cell_state;
            default: next_state = cell_state;
          endcase  // [RL7]
        end
      end
      `CLC_MODE_LATCH:
      begin
        if (g3)
          next_state = 1'b0;  // [RL8]
        else if (g4)
          next_state = 1'b1;  // [RL8]
        else if (g1)
          next_state = g2;  // [RL8]
      end
      default:
        next_state = 1'b0;
    endcase
    if (!cell_enable || comb_mode)
      next_state = 1'b0;
  end

  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cell_state <= 1'b0;
    end
    else
    begin
      cell_state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // cell output
  // ----------------------------------------------------------------
  reg next_out;

  always @*
  begin
    case (mode)
      `CLC_MODE_AND_OR: next_out = and_or_val;  // [RL1]
      `CLC_MODE_OR_XOR: next_out = or_xor_val;  // [RL2]
      `CLC_MODE_AND4:   next_out = and4_val;    // [RL3]
      default:          next_out = next_state;
    endcase
    // a disabled cell drives low rather than a stale value
    if (!cell_enable)
      next_out = 1'b0;
  end

  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cell_out <= 1'b0;
    end
    else
    begin
      cell_out <= next_out;
    end
  end

  // ----------------------------------------------------------------
  // register reads
  // ----------------------------------------------------------------
  always @*
  begin
    next_rdata = {`CLC_DATA_W{1'b0}};
    case (reg_addr)
      `CLC_IDX_CTRL_LO:
      begin
        next_rdata = cell_control_low;
        next_rdata[`CLC_CL_GATES_HI:`CLC_CL_GATES_LO] = gate;
        next_rdata[`CLC_CL_OUT] = cell_out;
      end
      `CLC_IDX_CTRL_HI:
        next_rdata = {12'h000, cell_control_high};  // [RL11]
      `CLC_IDX_SEL_LO:
        next_rdata = gate_input_select_low;
      `CLC_IDX_SEL_HI:
        next_rdata = gate_input_select_high;
      default:
        next_rdata = {`CLC_DATA_W{1'b0}};
    endcase
  end

  // read data stands only in the cycle after the strobe
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      reg_rdata <= {`CLC_DATA_W{1'b0}};
    end
    else if (reg_rd)
    begin
      reg_rdata <= next_rdata;
    end
    else
    begin
      reg_rdata <= {`CLC_DATA_W{1'b0}};
    end
  end

endmodule // clc_cell

// >>> verif/clc_cell_props.sv
// Purpose: port checks of the logic cell
// Assumes: config seen only through write strobes
// Notes:   gate one rise is high now, low last cycle
`timescale 1ns/1ps
`include "clc_map.vh"

module clc_cell_props
(
  input wire        clk,
  input wire        arst_n,
  input wire [3:0]  reg_addr,
  input wire [15:0] reg_wdata,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [15:0] reg_rdata,
  input wire [3:0]  data_src,
  input wire        cell_out
);
  // ----------------
  // shadow of config
  // ----------------
  reg  [15:0] r [0:3];
  reg         gp;
  wire [3:0]  g;
  wire        e  = r[0][15];
  wire [2:0]  m  = r[0][2:0];
  wire [3:0]  pl = r[1][3:0];
  wire        ri = g[0] & ~gp;
  wire        f0 = (g[0] & g[1]) | (g[2] & g[3]);
  wire        f1 = (g[0] | g[1]) ^ (g[2] | g[3]);
  wire        f2 = &g;
  wire        ss = g[0] | g[1];
  wire        d4 = ~g[2] & (g[3] | g[1]);
  wire        d5 = ~g[2] & g[1] & g[3];
  wire        d6 = ~g[2] & g[1];
  // sources passed in, so the assign follows every source change
  function automatic logic gt(input logic [7:0] b, input logic [3:0] s);
    gt = (|({b[7], b[5], b[3], b[1]} & s)) | (|({b[6], b[4], b[2], b[0]} & ~s));
  endfunction
  assign g = {gt(r[3][15:8], data_src), gt(r[3][7:0], data_src), gt(r[2][15:8], data_src),
              gt(r[2][7:0], data_src)} ^ pl;
  // unmapped indices dropped, as the port does
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      r[0] <= 16'h0000;
      r[1] <= 16'h0000;
      r[2] <= 16'h0000;
      r[3] <= 16'h0000;
      gp   <= 1'b0;
    end
    else
    begin
      gp <= g[0];
      if (reg_wr && reg_addr[3:2] == 2'h0)
        r[reg_addr[1:0]] <= reg_wdata;
    end
  end
  // ----------------
  // properties
  // ----------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  property p_aor;
    e && m == 3'h0 |=> cell_out == $past(f0);
  endproperty
  a_aor: assert property (p_aor) else $error("and-or wrong");
  property p_oxr;
    e && m == 3'h1 |=> cell_out == $past(f1);
  endproperty
  a_oxr: assert property (p_oxr) else $error("or-xor wrong");
  property p_and4;
    e && m == 3'h2 |=> cell_out == $past(f2);
  endproperty
  a_and4: assert property (p_and4) else $error("and4 wrong");
  property p_sr;
    e && m == 3'h3 && (ss || g[2] || g[3]) |=> cell_out == $past(ss);
  endproperty
  a_sr: assert property (p_sr) else $error("sr wrong");
  property p_dff;
    e && m == 3'h4 && (g[2] || g[3] || ri) |=> cell_out == $past(d4);
  endproperty
  a_dff: assert property (p_dff) else $error("dff wrong");
  property p_dff2;
    e && m == 3'h5 && (g[2] || ri) |=> cell_out == $past(d5);
  endproperty
  a_dff2: assert property (p_dff2) else $error("dff2 wrong");
  property p_jk;
    e && m == 3'h6 && (g[2] || (ri && g[1] != g[3])) |=> cell_out == $past(d6);
  endproperty
  a_jk: assert property (p_jk) else $error("jk wrong");
  property p_lat;
    e && m == 3'h7 && (g[2] || g[3] || g[0]) |=> cell_out == $past(d4);
  endproperty
  a_lat: assert property (p_lat) else $error("latch wrong");
  property p_hi;
    reg_rd && reg_addr == `CLC_IDX_CTRL_HI |=> reg_rdata == {12'h000, $past(pl)};
  endproperty
  a_hi: assert property (p_hi) else $error("ctrl high read wrong");
  cover property (e && m == 3'h6 && ri);
  cover property (e && m == 3'h7 && g[0]);
  cover property (reg_rd && reg_addr == `CLC_IDX_CTRL_HI);
endmodule // clc_cell_props

// >>> verif/clc_src_model.sv
// Purpose: data sources seen by the logic cell
// Assumes: levels synchronous to clk
// Notes:   slow holds each value two cycles
`timescale 1ns/1ps

module clc_src_model
(
  input  wire       clk,
  input  wire       arst_n,
  input  wire [3:0] pat,
  input  wire       slow,
  output reg  [3:0] data_src
);
  reg ph;
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ph       <= 1'b0;
      data_src <= 4'h0;
    end
    else
    begin
      ph <= ~ph;
      if (!slow || ph)
        data_src <= pat;
    end
  end
endmodule // clc_src_model

// >>> verif/tb.sv
// Purpose: self-checking bench of the logic cell
// Assumes: strobe register port, 50 MHz clock
// Notes:   a shadow model predicts cell_out every cycle
`timescale 1ns/1ps
`include "clc_map.vh"

module tb;
  localparam [47:0] sl_cfg = {16'h69c3, 16'h5560, 16'haa90};
  localparam [47:0] sh_cfg = {16'h2190, 16'h4409, 16'h0002};
  localparam [11:0] pl_cfg = {4'ha, 4'h5, 4'h0};
  reg         clk;
  reg         arst_n;
  reg  [3:0]  reg_addr;
  reg  [15:0] reg_wdata;
  reg         reg_wr;
  reg         reg_rd;
  wire [15:0] reg_rdata;
  wire [3:0]  data_src;
  wire        cell_out;
  reg  [3:0]  pat;
  reg         slow;
  reg  [15:0] r [0:3];
  reg         gp;
  reg         st;
  reg         eo;
  reg         f;
  reg         on;
  wire [3:0]  g;
  wire        ri;
  integer     fails;
  integer     compares;
  integer     i;
  integer     n;
  integer     k;
  clc_cell u_clc_cell (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .data_src(data_src), .cell_out(cell_out));
  clc_src_model u_clc_src_model (.clk(clk), .arst_n(arst_n), .pat(pat), .slow(slow), .data_src(data_src));
  always #10 clk = ~clk;
  // ----------------
  // reference cell
  // ----------------
  // sources passed in, so the assign follows every source change
  function automatic logic gt(input logic [7:0] b, input logic [3:0] s);
    gt = (|({b[7], b[5], b[3], b[1]} & s)) | (|({b[6], b[4], b[2], b[0]} & ~s));
  endfunction
  assign g  = {gt(r[3][15:8], data_src), gt(r[3][7:0], data_src), gt(r[2][15:8], data_src),
               gt(r[2][7:0], data_src)} ^ r[1][3:0];
  assign ri = g[0] & ~gp;
  always @*
  begin
    case (r[0][2:0])
      3'h0: f = (g[0] & g[1]) | (g[2] & g[3]);
      3'h1: f = (g[0] | g[1]) ^ (g[2] | g[3]);
      3'h2: f = &g;
      3'h3: f = g[0] | g[1] | (~(g[2] | g[3]) & st);
      3'h4: f = ~g[2] & (g[3] | (ri ? g[1] : st));
      3'h5: f = ~g[2] & (ri ? g[1] & g[3] : st);
      3'h6: f = ~g[2] & (ri ? (g[1] & ~st) | (~g[3] & st) : st);
      default: f = ~g[2] & (g[3] | (g[0] ? g[1] : st));
    endcase
  end
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      r[0] <= 16'h0000;
      r[1] <= 16'h0000;
      r[2] <= 16'h0000;
      r[3] <= 16'h0000;
      gp   <= 1'b0;
      st   <= 1'b0;
      eo   <= 1'b0;
    end
    else
    begin
      gp <= g[0];
      st <= r[0][15] & (r[0][2:0] > 3'h2) & f;
      eo <= r[0][15] & f;
      if (reg_wr && reg_addr[3:2] == 2'h0)
        r[reg_addr[1:0]] <= reg_wdata;
    end
  end
  // ----------------
  // tasks
  // ----------------
  task cmp16(input [3:0] a, input [15:0] e, input [15:0] s);
  begin
    compares = compares + 1;
    if (e !== s)
    begin
      fails = fails + 1;
      $display("ERROR reg %h expected %h seen %h", a, e, s);
    end
  end
  endtask
  task cmp1(input e, input s);
  begin
    compares = compares + 1;
    if (e !== s)
    begin
      fails = fails + 1;
      $display("ERROR cell_out expected %b seen %b", e, s);
    end
  end
  endtask
  task wr(input [3:0] a, input [15:0] d);
  begin
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  end
  endtask
  // read data stand only in the cycle after the strobe
  task rd(input [3:0] a, input [15:0] e);
  begin
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    cmp16(a, e, reg_rdata);
    @(posedge clk);
  end
  endtask
  task end_sim;
  begin
    $display("TB: compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask
  always @(negedge clk)
    if (on)
      cmp1(eo, cell_out);
  // ----------------
  // sequence
  // ----------------
  initial
  begin
    repeat (5000) @(posedge clk);
    fails = fails + 1;
    end_sim;
  end
  initial
  begin
    clk       = 1'b0;
    arst_n    = 1'b0;
    reg_addr  = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    pat       = 4'h0;
    slow      = 1'b0;
    on        = 1'b0;
    fails     = 0;
    compares  = 0;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    on = 1'b1;
    rd(`CLC_IDX_CTRL_LO, 16'h0000);
    rd(`CLC_IDX_CTRL_HI, 16'h0000);
    rd(`CLC_IDX_SEL_LO, 16'h0000);
    wr(`CLC_IDX_CTRL_HI, 16'hffff);
    rd(`CLC_IDX_CTRL_HI, 16'h000f);
    wr(4'hf, 16'hffff);
    rd(4'hf, 16'h0000);
    for (i = 0; i < 3; i = i + 1)
    begin
      wr(`CLC_IDX_SEL_LO, sl_cfg[16*i +: 16]);
      rd(`CLC_IDX_SEL_LO, sl_cfg[16*i +: 16]);
      wr(`CLC_IDX_SEL_HI, sh_cfg[16*i +: 16]);
      rd(`CLC_IDX_SEL_HI, sh_cfg[16*i +: 16]);
      wr(`CLC_IDX_CTRL_HI, {12'h000, pl_cfg[4*i +: 4]});
      slow <= (i == 2);
      for (n = 0; n < 8; n = n + 1)
      begin
        wr(`CLC_IDX_CTRL_LO, {1'b1, 12'h000, n[2:0]});
        for (k = 0; k < 32; k = k + 1)
        begin
          pat <= k[3:0] ^ i[3:0];
          @(posedge clk);
        end
      end
    end
    // enable off must force the output low
    wr(`CLC_IDX_CTRL_LO, 16'h0007);
    repeat (3) @(posedge clk);
    // sources held at 4'hd: gate status after polarity 4'ha, cell_out low
    rd(`CLC_IDX_CTRL_LO, 16'h0507);
    end_sim;
  end
endmodule // tb

bind clc_cell clc_cell_props u_props (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .data_src(data_src), .cell_out(cell_out));
